//--- inc/serial_unit_pkg.sv
// Register map, field layout and frame constants of the serial unit
package serial_unit_pkg;
  localparam int          AW            = 8;
  localparam int          DW            = 32;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_TX_HOLD   = 8'h08;
  localparam logic [7:0]  OFS_RX_DATA   = 8'h0C;
  localparam logic [7:0]  OFS_DIVISOR   = 8'h10;
  // Control field positions
  localparam int C_TX_EN   = 0;
  localparam int C_RX_EN   = 1;
  localparam int C_TIE     = 2;
  localparam int C_TX_END_IRQ_ENABLE    = 3;
  localparam int C_RIE     = 4;
  localparam int C_MPWAIT  = 5;
  localparam int C_CHR7    = 6;
  localparam int C_PAR_EN  = 7;
  localparam int C_PAR_ODD = 8;
  localparam int C_MP_FMT  = 9;
  localparam int C_STOP2   = 10;
  // Status field positions
  localparam int S_TBE     = 0;
  localparam int S_TX_END_FLAG    = 1;
  localparam int S_RXFULL  = 2;
  localparam int S_OVR     = 3;
  localparam int S_FER     = 4;
  localparam int S_PER     = 5;
  localparam int S_MULTIDROP_BIT_RECEIVED    = 6;
  localparam int S_MULTIDROP_BIT_TO_SEND    = 7;
  localparam logic [15:0] DIV_RESET     = 16'h0000;
  localparam logic [3:0]  OVERSAMPLE_LAST = 4'hF;  // 16 basic-clock pulses per bit
  localparam logic [3:0]  SAMPLE_PHASE  = 4'h7;    // 8th pulse
  localparam logic [3:0]  BITS_8        = 4'h8;
  localparam logic [3:0]  BITS_7        = 4'h7;

  typedef struct packed {
    logic stop2;
    logic mp_fmt;
    logic par_odd;
    logic par_en;
    logic chr7;
    logic mp_wait;
    logic rx_irq_enable;
    logic tx_end_irq_enable;
    logic tx_empty_irq_enable;
    logic rx_en;
    logic tx_en;
  } ctrl_t;

  typedef struct packed {
    logic multidrop_bit_to_send;
    logic multidrop_bit_received;
    logic parity_err_flag;
    logic framing_err_flag;
    logic ovr;
    logic rx_full;
    logic tx_end_flag;
    logic tbe;
  } status_t;

  localparam ctrl_t   CTRL_RESET   = '0;
  localparam status_t STATUS_RESET = 8'h03;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b011,
    TX_EXTRA = 3'b010,
    TX_STOP1 = 3'b110,
    TX_STOP2 = 3'b111
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b011,
    RX_EXTRA = 3'b010,
    RX_STOP  = 3'b110
  } rx_state_t;
endpackage : serial_unit_pkg

//--- hw/serial_unit.sv
// Asynchronous serial transmitter and receiver with multidrop addressing
`timescale 1ns/1ns
module serial_unit (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        RXD,
  output logic             TXD,
  output logic             TX_EMPTY_IRQ,
  output logic             TX_END_IRQ,
  output logic             RX_FULL_IRQ,
  output logic             RX_ERROR_IRQ
);

  serial_unit_pkg::ctrl_t     ctrl_q;
  serial_unit_pkg::status_t   stat_q;
  logic [15:0]                div_q;
  logic [15:0]                div_cnt_q;
  logic                       tick;
  logic [7:0]                 tx_holding_reg;
  logic [7:0]                 rx_data_reg;

  serial_unit_pkg::tx_state_t tx_state_q;
  logic [7:0]                 tx_shift_reg;
  logic                       tx_extra_q;
  logic [3:0]                 tx_phase_q;
  logic [3:0]                 tx_bit_q;
  logic                       tx_load;
  logic                       tx_stop_entry;

  serial_unit_pkg::rx_state_t rx_state_q;
  logic [7:0]                 rx_shift_reg;
  logic                       rx_extra_q;
  logic [3:0]                 rx_phase_q;
  logic [3:0]                 rx_bit_q;
  logic                       rxd_prev_q;
  logic                       rx_done;
  logic                       rx_skip;
  logic                       rx_per;
  logic                       rx_fer;

  logic wr_ctrl;
  logic wr_stat;
  logic wr_tx;
  logic sample_now;
  logic bit_end_tx;

  function automatic logic [3:0] data_bits(input serial_unit_pkg::ctrl_t c);
    data_bits = c.chr7 ? serial_unit_pkg::BITS_7 : serial_unit_pkg::BITS_8;
  endfunction : data_bits

  function automatic logic has_extra(input serial_unit_pkg::ctrl_t c);
    has_extra = c.mp_fmt | c.par_en;
  endfunction : has_extra

  // Parity over the used data bits only; 7-bit mode masks bit 7
  function automatic logic parity_of(input logic [7:0] d, input serial_unit_pkg::ctrl_t c);
    logic [7:0] m;
    m = c.chr7 ? {1'b0, d[6:0]} : d;
    parity_of = (^m) ^ c.par_odd;
  endfunction : parity_of

  assign wr_ctrl = WR && (ADDR == serial_unit_pkg::OFS_CTRL);
  assign wr_stat = WR && (ADDR == serial_unit_pkg::OFS_STATUS);
  assign wr_tx   = WR && (ADDR == serial_unit_pkg::OFS_TX_HOLD);

  // Basic clock: one tick every div_q+1 system clocks, 16 ticks per bit
  assign tick = (div_cnt_q == div_q);

  always_ff @(posedge CLK) begin
    if (!RESET_N || tick) begin
      div_cnt_q <= 16'h0000;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      div_q <= serial_unit_pkg::DIV_RESET;
    end else if (WR && ADDR == serial_unit_pkg::OFS_DIVISOR) begin
      div_q <= WDATA[15:0];
    end
  end

  // Control; the hardware clear of the ID wait yields to a software write
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl_q <= serial_unit_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= serial_unit_pkg::ctrl_t'(WDATA[serial_unit_pkg::C_STOP2:0]);
    end else if (rx_done && ctrl_q.mp_wait && rx_extra_q) begin
      ctrl_q.mp_wait <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      tx_holding_reg <= 8'h00;
    end else if (wr_tx) begin
      tx_holding_reg <= WDATA[7:0];
    end
  end

  // Transmitter
  assign bit_end_tx    = tick && (tx_phase_q == serial_unit_pkg::OVERSAMPLE_LAST);
  assign tx_stop_entry = bit_end_tx && ((tx_state_q == serial_unit_pkg::TX_EXTRA) ||
                         (tx_state_q == serial_unit_pkg::TX_DATA && tx_bit_q == data_bits(ctrl_q) - 4'h1 &&
                          !has_extra(ctrl_q)));
  assign tx_load = ctrl_q.tx_en && !stat_q.tbe &&
                   ((tx_state_q == serial_unit_pkg::TX_IDLE) || tx_stop_entry);

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      tx_shift_reg <= 8'h00;
      tx_extra_q   <= 1'b0;
    end else if (tx_load) begin
      tx_shift_reg <= tx_holding_reg;
      tx_extra_q   <= ctrl_q.mp_fmt ? stat_q.multidrop_bit_to_send : parity_of(tx_holding_reg, ctrl_q);
    end else if (bit_end_tx && tx_state_q == serial_unit_pkg::TX_DATA) begin
      tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
    end
  end

  // Pending word after stop: chosen at stop entry, used when stops end
  logic tx_next_q;

  always_ff @(posedge CLK) begin
    if (!RESET_N || !ctrl_q.tx_en) begin
      tx_state_q <= serial_unit_pkg::TX_IDLE;
      tx_phase_q <= 4'h0;
      tx_bit_q   <= 4'h0;
      tx_next_q  <= 1'b0;
    end else begin
      if (tick) begin
        tx_phase_q <= tx_phase_q + 4'h1;
      end
      case (tx_state_q)
        serial_unit_pkg::TX_IDLE: begin
          tx_phase_q <= 4'h0;
          if (tx_load) begin
            tx_state_q <= serial_unit_pkg::TX_START;
          end
        end
        serial_unit_pkg::TX_START: begin
          tx_bit_q <= 4'h0;
          if (bit_end_tx) begin
            tx_state_q <= serial_unit_pkg::TX_DATA;
          end
        end
        serial_unit_pkg::TX_DATA: begin
          if (bit_end_tx) begin
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == data_bits(ctrl_q) - 4'h1) begin
              tx_state_q <= has_extra(ctrl_q) ? serial_unit_pkg::TX_EXTRA : serial_unit_pkg::TX_STOP1;
            end
          end
        end
        serial_unit_pkg::TX_EXTRA: begin
          if (bit_end_tx) begin
            tx_state_q <= serial_unit_pkg::TX_STOP1;
          end
        end
        serial_unit_pkg::TX_STOP1: begin
          if (bit_end_tx) begin
            if (ctrl_q.stop2) begin
              tx_state_q <= serial_unit_pkg::TX_STOP2;
            end else begin
              tx_state_q <= tx_next_q ? serial_unit_pkg::TX_START : serial_unit_pkg::TX_IDLE;
            end
          end
        end
        serial_unit_pkg::TX_STOP2: begin
          if (bit_end_tx) begin
            tx_state_q <= tx_next_q ? serial_unit_pkg::TX_START : serial_unit_pkg::TX_IDLE;
          end
        end
        default: tx_state_q <= serial_unit_pkg::TX_IDLE;
      endcase
      if (tx_stop_entry) begin
        tx_next_q <= tx_load;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      TXD <= 1'b1;
    end else begin
      case (tx_state_q)
        serial_unit_pkg::TX_START: TXD <= 1'b0;
        serial_unit_pkg::TX_DATA:  TXD <= tx_shift_reg[0];
        serial_unit_pkg::TX_EXTRA: TXD <= tx_extra_q;
        default:                   TXD <= 1'b1;
      endcase
    end
  end

  // Receiver; the line input is taken as synchronous
  assign sample_now = tick && (rx_phase_q == serial_unit_pkg::SAMPLE_PHASE);
  assign rx_done    = sample_now && (rx_state_q == serial_unit_pkg::RX_STOP);
  assign rx_skip    = ctrl_q.mp_wait && !rx_extra_q;
  assign rx_per     = ctrl_q.par_en && !ctrl_q.mp_fmt &&
                      (rx_extra_q != parity_of(rx_shift_reg, ctrl_q));
  assign rx_fer     = !RXD;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rxd_prev_q <= 1'b1;
    end else begin
      rxd_prev_q <= RXD;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N || !ctrl_q.rx_en) begin
      rx_state_q   <= serial_unit_pkg::RX_IDLE;
      rx_phase_q   <= 4'h0;
      rx_bit_q     <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_extra_q   <= 1'b0;
    end else begin
      if (tick) begin
        rx_phase_q <= rx_phase_q + 4'h1;
      end
      case (rx_state_q)
        serial_unit_pkg::RX_IDLE: begin
          // Errors block reception until software clears them
          if (rxd_prev_q && !RXD && !(stat_q.ovr || stat_q.framing_err_flag || stat_q.parity_err_flag)) begin
            rx_state_q <= serial_unit_pkg::RX_START;
            rx_phase_q <= 4'h0;
          end
        end
        serial_unit_pkg::RX_START: begin
          rx_bit_q <= 4'h0;
          if (sample_now) begin
            // A glitch shorter than half a bit is not a start bit
            rx_state_q <= RXD ? serial_unit_pkg::RX_IDLE : serial_unit_pkg::RX_DATA;
          end
        end
        serial_unit_pkg::RX_DATA: begin
          if (sample_now) begin
            rx_shift_reg <= ctrl_q.chr7 ? {1'b0, RXD, rx_shift_reg[6:1]} : {RXD, rx_shift_reg[7:1]};
            rx_bit_q     <= rx_bit_q + 4'h1;
            if (rx_bit_q == data_bits(ctrl_q) - 4'h1) begin
              rx_state_q <= has_extra(ctrl_q) ? serial_unit_pkg::RX_EXTRA : serial_unit_pkg::RX_STOP;
            end
          end
        end
        serial_unit_pkg::RX_EXTRA: begin
          if (sample_now) begin
            rx_extra_q <= RXD;
            rx_state_q <= serial_unit_pkg::RX_STOP;
          end
        end
        serial_unit_pkg::RX_STOP: begin
          // Only the first stop bit is checked; the next start edge may follow
          if (sample_now) begin
            rx_state_q <= serial_unit_pkg::RX_IDLE;
          end
        end
        default: rx_state_q <= serial_unit_pkg::RX_IDLE;
      endcase
      if (rx_state_q == serial_unit_pkg::RX_START && !has_extra(ctrl_q)) begin
        rx_extra_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rx_data_reg <= 8'h00;
    end else if (rx_done && !rx_skip && !stat_q.rx_full) begin
      rx_data_reg <= rx_shift_reg;
    end
  end

  // Status flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      stat_q <= serial_unit_pkg::STATUS_RESET;
    end else begin
      if (wr_stat) begin
        stat_q.multidrop_bit_to_send    <= WDATA[serial_unit_pkg::S_MULTIDROP_BIT_TO_SEND];
        stat_q.tx_end_flag    <= stat_q.tx_end_flag    & WDATA[serial_unit_pkg::S_TX_END_FLAG];
        stat_q.rx_full <= stat_q.rx_full & WDATA[serial_unit_pkg::S_RXFULL];
        stat_q.ovr     <= stat_q.ovr     & WDATA[serial_unit_pkg::S_OVR];
        stat_q.framing_err_flag     <= stat_q.framing_err_flag     & WDATA[serial_unit_pkg::S_FER];
        stat_q.parity_err_flag     <= stat_q.parity_err_flag     & WDATA[serial_unit_pkg::S_PER];
        stat_q.multidrop_bit_received    <= stat_q.multidrop_bit_received    & WDATA[serial_unit_pkg::S_MULTIDROP_BIT_RECEIVED];
      end
      if (wr_tx) begin
        stat_q.tbe  <= 1'b0;
        stat_q.tx_end_flag <= 1'b0;
      end
      if (!ctrl_q.tx_en || tx_load) begin
        stat_q.tbe <= 1'b1;
      end
      if (tx_stop_entry && !tx_load) begin
        stat_q.tx_end_flag <= 1'b1;
      end
      if (rx_done && !rx_skip) begin
        if (ctrl_q.mp_fmt) begin
          stat_q.multidrop_bit_received <= rx_extra_q;
        end
        if (stat_q.rx_full) begin
          stat_q.ovr <= 1'b1;
        end
        if (rx_per) begin
          stat_q.parity_err_flag <= 1'b1;
        end
        if (rx_fer) begin
          stat_q.framing_err_flag <= 1'b1;
        end
        if (!stat_q.rx_full && !rx_per && !rx_fer) begin
          stat_q.rx_full <= 1'b1;
        end
      end
    end
  end

  // Interrupt request levels follow flag and enable
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      TX_EMPTY_IRQ <= 1'b0;
      TX_END_IRQ   <= 1'b0;
      RX_FULL_IRQ  <= 1'b0;
      RX_ERROR_IRQ <= 1'b0;
    end else begin
      TX_EMPTY_IRQ <= ctrl_q.tx_empty_irq_enable && stat_q.tbe;
      TX_END_IRQ   <= ctrl_q.tx_end_irq_enable && stat_q.tx_end_flag;
      RX_FULL_IRQ  <= ctrl_q.rx_irq_enable && stat_q.rx_full;
      RX_ERROR_IRQ <= ctrl_q.rx_irq_enable && (stat_q.ovr || stat_q.framing_err_flag || stat_q.parity_err_flag);
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge CLK) begin
    if (!RESET_N || !RD) begin
      RDATA <= 32'h0000_0000;
    end else begin
      case (ADDR)
        serial_unit_pkg::OFS_CTRL:    RDATA <= {21'h00_0000, ctrl_q};
        serial_unit_pkg::OFS_STATUS:  RDATA <= {24'h00_0000, stat_q};
        serial_unit_pkg::OFS_TX_HOLD: RDATA <= {24'h00_0000, tx_holding_reg};
        serial_unit_pkg::OFS_RX_DATA: RDATA <= {24'h00_0000, rx_data_reg};
        serial_unit_pkg::OFS_DIVISOR: RDATA <= {16'h0000, div_q};
        default:                      RDATA <= 32'h0000_0000;
      endcase
    end
  end

endmodule : serial_unit

//--- tb/serial_unit_sva.sv
// Port-level checks of the serial unit, bound into every instance
`timescale 1ns/1ns
module serial_unit_sva (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        RXD,
  input wire logic        TXD,
  input wire logic        TX_EMPTY_IRQ,
  input wire logic        TX_END_IRQ,
  input wire logic        RX_FULL_IRQ,
  input wire logic        RX_ERROR_IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Figures assume divisor 0, so one bit is 16 clocks
  logic [7:0] low_run_q;
  logic [3:0] wr_hist_q;
  always_ff @(posedge CLK) begin
    low_run_q <= (!RESET_N || TXD) ? 8'h00 : low_run_q + 8'h01;
    wr_hist_q <= RESET_N ? {wr_hist_q[2:0], WR} : 4'h0;
  end
  property p_rdata_idle;
    !$past(RD) |-> RDATA == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_idle_after_reset;
    !$past(RESET_N) |-> TXD;
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset) else $error("line not idle after reset");
  // A recent write may abort a frame mid-bit, so those rises are skipped
  property p_bit_grid;
    $rose(TXD) && wr_hist_q == 4'h0 |-> low_run_q[3:0] == 4'h0 && low_run_q != 8'h00;
  endproperty
  a_bit_grid: assert property (p_bit_grid) else $error("low run not whole bits");
  // The request level lags the flag by one register, so the drop shows two edges on
  property p_load;
    WR && ADDR == serial_unit_pkg::OFS_TX_HOLD && TX_EMPTY_IRQ |-> ##2 !TX_EMPTY_IRQ ##[1:400] TX_EMPTY_IRQ;
  endproperty
  a_load: assert property (p_load) else $error("holding word not taken");
  // A write shows on a request level two edges later; such rises are not from the line
  property p_tx_end_flag_mark;
    $rose(TX_END_IRQ) && !$past(WR, 2) |-> TXD [*8];
  endproperty
  a_tx_end_flag_mark: assert property (p_tx_end_flag_mark) else $error("line not high after end");
  property p_stop_ctrl;
    WR && ADDR == serial_unit_pkg::OFS_CTRL && !WDATA[serial_unit_pkg::C_TX_EN] |-> ##3 TXD [*8];
  endproperty
  a_stop_ctrl: assert property (p_stop_ctrl) else $error("line not idle when disabled");
  property p_err_keeps_full;
    $rose(RX_ERROR_IRQ) && !$past(WR, 2) |-> RX_FULL_IRQ == $past(RX_FULL_IRQ);
  endproperty
  a_err_keeps_full: assert property (p_err_keeps_full) else $error("full flag moved on error");
  property p_full_at_stop;
    $rose(RX_FULL_IRQ) && !$past(WR, 2) |-> RXD && $past(RXD);
  endproperty
  a_full_at_stop: assert property (p_full_at_stop) else $error("full without stop bit");
  c_overrun: cover property (RX_ERROR_IRQ && RX_FULL_IRQ);
  c_tx_end: cover property ($rose(TX_END_IRQ) && !$past(WR, 2));
  c_read: cover property ($past(RD) && RDATA != 32'h0000_0000);
endmodule : serial_unit_sva
bind serial_unit serial_unit_sva i_sva (.CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .RXD, .TXD,
  .TX_EMPTY_IRQ, .TX_END_IRQ, .RX_FULL_IRQ, .RX_ERROR_IRQ);

//--- tb/remote_station.sv
// Remote station on the shared line: frames to the unit and a decoder of its output
`timescale 1ns/1ns
module remote_station #(
  parameter int BIT = 16
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic [9:0] got_q[$];
  time        at_q[$];
  int         nbits = 8;
  logic       has_extra = 1'b0;
  initial line_out = 1'b1;
  // Stop 0 makes a framing fault on purpose
  task automatic send(input logic [7:0] dd, input logic extra, input logic stop);
    repeat (BIT) @(posedge clk) line_out <= 1'b0;
    for (int i = 0; i < nbits; i++) repeat (BIT) @(posedge clk) line_out <= dd[i];
    if (has_extra) repeat (BIT) @(posedge clk) line_out <= extra;
    repeat (BIT) @(posedge clk) line_out <= stop;
    repeat (BIT) @(posedge clk) line_out <= 1'b1;
  endtask : send
  // Decoded frame: stop in [9], extra bit in [8], sampled mid-bit
  always begin : decode
    logic [9:0] w;
    @(negedge line_in);
    at_q.push_back($time);
    w = 10'h000;
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i <= nbits + has_extra; i++) begin
      repeat (BIT) @(posedge clk);
      w[(i == nbits + has_extra) ? 9 : ((i == nbits) ? 8 : i)] = line_in;
    end
    got_q.push_back(w);
  end
endmodule : remote_station

//--- tb/async_serial_tx_rx_multidrop_test.sv
// Self-checking bench of the serial unit against a remote station model
`timescale 1ns/1ns
`define CHK(a, e) begin \
  samples_checked++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); \
  end \
end
module async_serial_tx_rx_multidrop_test;
  logic                   clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic [7:0]             addr = 8'h00;
  logic [31:0]            wdata = 32'h0000_0000;
  logic                   wr_s = 1'b0;
  logic                   rd_s = 1'b0;
  logic [31:0]            rdata;
  logic                   rxd;
  logic                   txd;
  logic                   tx_empty_irq;
  logic                   tx_end_irq;
  logic                   rx_full_irq;
  logic                   rx_error_irq;
  int                     miscompares = 0;
  int                     samples_checked = 0;
  int                     cycles = 0;
  logic [31:0]            seed = 32'hdd91_1fe4;
  logic [31:0]            v;
  logic [7:0]             d[2];
  serial_unit_pkg::ctrl_t c;
  always #50 clk = ~clk;
  serial_unit i_dut (.CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .RXD(rxd), .TXD(txd), .TX_EMPTY_IRQ(tx_empty_irq), .TX_END_IRQ(tx_end_irq),
    .RX_FULL_IRQ(rx_full_irq), .RX_ERROR_IRQ(rx_error_irq));
  remote_station #(.BIT(16)) i_peer (.clk(clk), .line_in(txd), .line_out(rxd));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Frame as the station decodes it for format code f
  function automatic logic [9:0] exp_frame(logic [7:0] dd, int f);
    logic [7:0] m;
    m = f[0] ? {1'b0, dd[6:0]} : dd;
    return {1'b1, f[2] ? f[1] : (f[1] ? (^m) ^ f[0] : 1'b0), m};
  endfunction : exp_frame
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    @(posedge clk);
    addr  <= a;
    wdata <= dv;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd
  task automatic rx_frame(input logic [7:0] dd, input logic x, input logic stop);
    i_peer.send(dd, x, stop);
    rd(serial_unit_pkg::OFS_STATUS);
  endtask : rx_frame
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("timeout at %0t", $time);
      stop_test();
    end
  end
  initial begin
    c = '0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd(serial_unit_pkg::OFS_STATUS);
    `CHK(v, 32'(serial_unit_pkg::STATUS_RESET))
    rd(serial_unit_pkg::OFS_CTRL);
    `CHK(v, 32'h0000_0000)
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14);
    `CHK(v, 32'h0000_0000)
    `CHK(txd, 1'b1)
    $display("test reset done");
    for (int f = 0; f < 8; f++) begin
      c = '0;
      c.tx_en = 1'b1;
      c.tx_empty_irq_enable = 1'b1;
      c.tx_end_irq_enable = 1'b1;
      c.chr7 = f[0];
      c.par_en = f[1];
      c.par_odd = f[0];
      c.mp_fmt = f[2];
      c.stop2 = f[1] ^ f[2];
      i_peer.nbits = f[0] ? 7 : 8;
      i_peer.has_extra = f[1] | f[2];
      wr(serial_unit_pkg::OFS_CTRL, 32'(c));
      wr(serial_unit_pkg::OFS_STATUS, {24'h00_0000, f[1], 7'h7e});
      for (int k = 0; k < 2; k++) begin
        d[k] = 8'(rnd());
        wr(serial_unit_pkg::OFS_TX_HOLD, {24'h00_0000, d[k]});
        repeat (3) @(posedge clk);
        wait (tx_empty_irq === 1'b1);
      end
      wait (tx_end_irq === 1'b1);
      repeat (16) @(posedge clk);
      `CHK(i_peer.got_q.size(), 2)
      for (int k = 0; k < 2; k++) `CHK(i_peer.got_q[k], exp_frame(d[k], f))
      `CHK(i_peer.at_q[1] - i_peer.at_q[0], 1600 * (10 - f[0] + (f[1] | f[2]) + (f[1] ^ f[2])))
      i_peer.got_q.delete();
      i_peer.at_q.delete();
    end
    wr(serial_unit_pkg::OFS_TX_HOLD, 32'h0000_0055);
    wr(serial_unit_pkg::OFS_TX_HOLD, 32'h0000_00aa);
    rd(serial_unit_pkg::OFS_STATUS);
    `CHK(v[serial_unit_pkg::S_TBE], 1'b0)
    c.tx_en = 1'b0;
    wr(serial_unit_pkg::OFS_CTRL, 32'(c));
    rd(serial_unit_pkg::OFS_STATUS);
    `CHK(v[serial_unit_pkg::S_TBE], 1'b1)
    repeat (200) @(posedge clk);
    $display("test transmit done");
    c = '0;
    c.rx_en = 1'b1;
    c.rx_irq_enable = 1'b1;
    c.par_en = 1'b1;
    i_peer.nbits = 8;
    i_peer.has_extra = 1'b1;
    wr(serial_unit_pkg::OFS_CTRL, 32'(c));
    d[0] = 8'(rnd());
    d[1] = 8'(rnd());
    rx_frame(d[0], ^d[0], 1'b1);
    `CHK(v[6:2], 5'h01)
    `CHK(rx_full_irq, 1'b1)
    rx_frame(d[1], ^d[1], 1'b1);
    `CHK(v[6:2], 5'h03)
    `CHK(rx_error_irq, 1'b1)
    rd(serial_unit_pkg::OFS_RX_DATA);
    `CHK(v, {24'h00_0000, d[0]})
    // Codes 1..3: parity fault, framing fault, both
    for (int e = 1; e < 4; e++) begin
      wr(serial_unit_pkg::OFS_STATUS, 32'h0000_0002);
      rx_frame(d[e[0]], (^d[e[0]]) ^ e[0], ~e[1]);
      `CHK(v[6:2], {1'b0, e[0], e[1], 2'b00})
      `CHK(rx_error_irq, 1'b1)
      rd(serial_unit_pkg::OFS_RX_DATA);
      `CHK(v, {24'h00_0000, d[e[0]]})
    end
    rx_frame(d[0], ^d[0], 1'b1);
    `CHK(v[6:2], 5'h0c)
    rd(serial_unit_pkg::OFS_RX_DATA);
    `CHK(v, {24'h00_0000, d[1]})
    $display("test receive done");
    wr(serial_unit_pkg::OFS_STATUS, 32'h0000_0002);
    c.mp_fmt = 1'b1;
    c.mp_wait = 1'b1;
    wr(serial_unit_pkg::OFS_CTRL, 32'(c));
    rx_frame(d[1], 1'b0, 1'b1);
    `CHK(v[6:2], 5'h00)
    rx_frame(d[0], 1'b0, 1'b0);
    `CHK(v[6:2], 5'h00)
    rx_frame(d[1], 1'b1, 1'b1);
    `CHK(v[6:2], 5'h11)
    `CHK(rx_full_irq, 1'b1)
    rd(serial_unit_pkg::OFS_RX_DATA);
    `CHK(v, {24'h00_0000, d[1]})
    rd(serial_unit_pkg::OFS_CTRL);
    `CHK(v[serial_unit_pkg::C_MPWAIT], 1'b0)
    wr(serial_unit_pkg::OFS_STATUS, 32'h0000_0002);
    rx_frame(d[0], 1'b0, 1'b1);
    `CHK(v[6:2], 5'h01)
    $display("test multidrop done");
    stop_test();
  end
endmodule : async_serial_tx_rx_multidrop_test
